//--- hdl/lrf_top.sv
// fault supervision logic for a six-row led backlight driver
//
// Overview of operation
// - protections other than overcurrent idle until soft-start completes
// - alarm is active-low open collector
// - policy strap picks one of two behaviours
// - overcurrent turns switch off, alarm released
// - overvoltage pulls alarm, shuts down, latches
// - thermal pulls alarm, off, auto restarts
// - drop policy: open row dropped, alarm high
// - strict policy: first open row latches shutdown
// - latch clears by enable toggle or power-on
// - power-on when supply drops then recovers
// - drop row once floating threshold reached
// - strict policy compares rows to short threshold
// - short latches after full masking time
// - drop policy disables short protection
// - new dimming phase restarts full masking
// - generators follow dimming, boost pauses low
// - start-up forces full dimming duty
`timescale 1ns/1ps
module lrf_top #(
    parameter longint MASK_CYC = lrf_pkg::SHORT_MASK_CYC // short masking cycles
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [lrf_pkg::ROWS-1:0] open_row_i, // row open detectors
    input wire logic [lrf_pkg::ROWS-1:0] short_row_i, // row above short threshold
    input wire logic ocp_i, // switch overcurrent
    input wire logic ovp_i, // output overvoltage
    input wire logic otp_i, // thermal shutdown flag
    input wire logic enable_i, // enable pin
    input wire logic dimming_input_i, // pwm dimming pin
    input wire logic ss_done_i, // soft-start finished
    input wire logic float_th_i, // floating row threshold reached
    input wire logic undervoltage_lockout_ok_i, // regulated_supply_pin above threshold
    input wire logic policy_i, // fault policy strap
    output logic alarm_out_n_o, // alarm output level
    output logic alarm_oe_o, // alarm pull-down enable
    output logic device_on_o, // device running
    output logic switch_on_o, // power switch allowed
    output logic boost_run_o, // boost converter active
    output logic [lrf_pkg::ROWS-1:0] gen_on_o, // current generators on
    output logic [lrf_pkg::ROWS-1:0] row_active_o, // rows in regulation
    output logic protect_o // protections armed
);
    import lrf_pkg::*;
    // ==========================================================
    // synchronised inputs
    lrf_sync_if sy();
    lrf_sync #(.W(21)) u_sync (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .async_i({policy_i, undervoltage_lockout_ok_i, float_th_i, ss_done_i, dimming_input_i,
                  enable_i, otp_i, ovp_i, ocp_i, short_row_i, open_row_i}),
        .sy(sy)
    );
    // ==========================================================
    // state
    lrf_state_type state, next_state; // control state
    logic [ROWS-1:0] rows, next_rows; // rows kept in regulation
    logic [TMR_W-1:0] tmr, next_tmr; // short masking timer
    logic dim_q, next_dim_q; // previous dimming level
    logic alarm_n, next_alarm_n; // alarm level
    logic sw_on, next_sw_on; // switch enable
    logic boost, next_boost; // boost run
    logic [ROWS-1:0] gen, next_gen; // generator enables
    logic policy_r, next_policy_r; // policy caught after reset
    logic pol_cap, next_pol_cap; // policy has been caught
    logic start, restart, dim_eff, short_any, open_hit;
    // true in the states where the converter and generators may run
    function automatic logic is_on(input lrf_state_type st);
        return (st == lrf_soft_s) || (st == lrf_run_s);
    endfunction
    // ==========================================================
    // decoded conditions
    always_comb begin
        // power-on or enable low forces a fresh start
        restart = !sy.enable || !sy.undervoltage_lockout_ok;
        start = sy.enable && sy.undervoltage_lockout_ok;
        // start-up runs at full duty from the cycle that leaves off, so a
        // floating row shows even with the dimming pin held low
        dim_eff = (state == lrf_soft_s || state == lrf_off_type_s) ? 1'b1 : sy.dimming_input;
        short_any = |(sy.short_row & rows);
        open_hit = |(sy.open_row & rows);
    end
    // ==========================================================
    // next state logic
    always_comb begin
        next_state = state;
        next_rows = rows;
        next_tmr = tmr;
        next_dim_q = sy.dimming_input;
        next_alarm_n = 1'b1;
        next_policy_r = policy_r;
        next_pol_cap = 1'b1;
        case (state)
            lrf_off_type_s: begin
                next_rows = ROW_ALL_ON; // rows reinitialised
                next_tmr = '0;
                // strap read while off: the synchroniser has refilled by the time
                // the enable level gets through, frozen from soft-start on
                next_policy_r = sy.policy;
                if (start && pol_cap) begin
                    next_state = lrf_soft_s;
                end
            end
            lrf_soft_s: begin
                if (restart) begin
                    next_state = lrf_off_type_s;
                end else if (sy.ss_done) begin
                    next_state = lrf_run_s;
                end
            end
            lrf_run_s: begin
                if (restart) begin
                    next_state = lrf_off_type_s;
                end else if (sy.ovp) begin
                    next_state = lrf_latch_s;
                end else if (sy.otp) begin
                    next_state = lrf_thermal_s;
                end else if (open_hit && policy_r != POLICY_DROP) begin
                    next_state = lrf_latch_s;
                end else begin
                    // drop open rows once threshold reached
                    if (policy_r == POLICY_DROP && sy.float_th) begin
                        next_rows = rows & ~sy.open_row;
                    end
                    // masking timer, strict policy only
                    if (policy_r == POLICY_DROP || !short_any || !sy.dimming_input) begin
                        next_tmr = '0;
                    end else if (sy.dimming_input && !dim_q) begin
                        next_tmr = '0;
                    end else if (longint'(tmr) >= MASK_CYC - 1) begin
                        next_state = lrf_latch_s;
                    end else begin
                        next_tmr = tmr + 1'b1;
                    end
                end
            end
            lrf_latch_s: begin
                // held until enable toggles or power cycles
                if (restart) begin
                    next_state = lrf_off_type_s;
                end
            end
            lrf_thermal_s: begin
                if (restart) begin
                    next_state = lrf_off_type_s;
                end else if (!sy.otp) begin
                    next_state = lrf_off_type_s; // auto restart
                end
            end
            default: begin
                next_state = lrf_off_type_s;
            end
        endcase
        // alarm low in latch and thermal states
        if (next_state == lrf_latch_s || next_state == lrf_thermal_s) begin
            next_alarm_n = 1'b0;
        end
        // overcurrent only cuts the switch, and with it the boost that follows it
        next_sw_on = is_on(next_state) && !sy.ocp;
        // boost pauses and generators off in dimming low
        next_boost = next_sw_on && dim_eff;
        next_gen = (is_on(next_state) && dim_eff) ? next_rows : '0;
    end
    // ==========================================================
    // registers
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= lrf_off_type_s;
            rows <= ROW_ALL_ON;
            tmr <= '0;
            dim_q <= 1'b0;
            alarm_n <= RST_ALARM_N;
            sw_on <= 1'b0;
            boost <= 1'b0;
            gen <= '0;
            policy_r <= POLICY_DROP;
            pol_cap <= 1'b0;
        end else begin
            state <= next_state;
            rows <= next_rows;
            tmr <= next_tmr;
            dim_q <= next_dim_q;
            alarm_n <= next_alarm_n;
            sw_on <= next_sw_on;
            boost <= next_boost;
            gen <= next_gen;
            policy_r <= next_policy_r;
            pol_cap <= next_pol_cap;
        end
    end
    // ==========================================================
    // outputs, all straight from flip-flops
    logic on_q, next_on; // device on flag
    logic prot_q, next_prot; // protections armed flag
    logic oe_q, next_oe; // alarm pull-down enable
    // output flags follow the state being entered, so they line up with it
    always_comb begin
        next_on = is_on(next_state);
        // faults other than overcurrent are only acted on in the run state
        next_prot = (next_state == lrf_run_s);
        // sink the line only while alarming
        next_oe = !next_alarm_n;
    end
    // output registers
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            on_q <= 1'b0;
            prot_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            on_q <= next_on;
            prot_q <= next_prot;
            oe_q <= next_oe;
        end
    end
    assign alarm_out_n_o = alarm_n;
    assign alarm_oe_o = oe_q; // line released unless alarming
    assign device_on_o = on_q;
    assign switch_on_o = sw_on;
    assign boost_run_o = boost;
    assign gen_on_o = gen;
    assign row_active_o = rows;
    assign protect_o = prot_q;
endmodule

//--- hdl/lrf_pkg.sv
// package of constants and types for the led row fault manager
package lrf_pkg;
    // ==========================================================
    // sizes
    localparam int ROWS = 6;
    // ==========================================================
    // timing
    localparam longint CLK_HZ = 64'd40000000;
    localparam longint SHORT_MASK_MS = 64'd100;
    // masking time in cycles, least time rounds up
    localparam longint SHORT_MASK_CYC = (SHORT_MASK_MS * CLK_HZ + 64'd999) / 64'd1000;
    localparam int TMR_W = 23;
    // ==========================================================
    // reset values
    localparam logic [ROWS-1:0] ROW_ALL_ON = 6'h3f;
    localparam logic RST_ALARM_N = 1'b1;
    // ==========================================================
    // policy levels
    localparam logic POLICY_DROP = 1'b1;
    // ==========================================================
    // control states
    typedef enum logic [2:0] {
        lrf_off_type_s, lrf_soft_s, lrf_run_s, lrf_latch_s, lrf_thermal_s
    } lrf_state_type;
endpackage

//--- hdl/lrf_sync_if.sv
// interface carrying synchronised detector levels between modules
`timescale 1ns/1ps
interface lrf_sync_if;
    import lrf_pkg::*;
    logic [ROWS-1:0] open_row; // open row flags
    logic [ROWS-1:0] short_row; // over short threshold flags
    logic ocp; // switch overcurrent
    logic ovp; // output overvoltage
    logic otp; // over temperature
    logic enable; // enable level
    logic dimming_input; // dimming input
    logic ss_done; // soft-start done
    logic float_th; // floating row threshold reached
    logic undervoltage_lockout_ok; // supply above upper threshold
    logic policy; // fault policy strap
    modport src (output open_row, short_row, ocp, ovp, otp, enable, dimming_input, ss_done,
                 float_th, undervoltage_lockout_ok, policy);
    modport dst (input open_row, short_row, ocp, ovp, otp, enable, dimming_input, ss_done,
                 float_th, undervoltage_lockout_ok, policy);
endinterface

//--- hdl/lrf_sync.sv
// two-flop synchroniser bank for all pin-level inputs
`timescale 1ns/1ps
module lrf_sync #(
    parameter int W = 24
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [W-1:0] async_i,
    lrf_sync_if.src sy
);
    import lrf_pkg::*;
    logic [W-1:0] meta; // first stage, read only by second stage
    logic [W-1:0] stab; // second stage
    logic [W-1:0] next_meta;
    logic [W-1:0] next_stab;
    // ==========================================================
    // next values
    always_comb begin
        next_meta = async_i;
        next_stab = meta;
    end
    // registers
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta <= '0;
            stab <= '0;
        end else begin
            meta <= next_meta;
            stab <= next_stab;
        end
    end
    // unpack into named levels
    assign sy.open_row = stab[5:0];
    assign sy.short_row = stab[11:6];
    assign sy.ocp = stab[12];
    assign sy.ovp = stab[13];
    assign sy.otp = stab[14];
    assign sy.enable = stab[15];
    assign sy.dimming_input = stab[16];
    assign sy.ss_done = stab[17];
    assign sy.float_th = stab[18];
    assign sy.undervoltage_lockout_ok = stab[19];
    assign sy.policy = stab[20];
endmodule

//--- test/lrf_top_chk.sv
// assertion checker for the led row fault manager
`timescale 1ns/1ps
module lrf_top_chk #(
    parameter longint MASK_CYC = 20 // short masking cycles
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [lrf_pkg::ROWS-1:0] open_row_i,
    input wire logic [lrf_pkg::ROWS-1:0] short_row_i,
    input wire logic ocp_i,
    input wire logic ovp_i,
    input wire logic otp_i,
    input wire logic enable_i,
    input wire logic dimming_input_i,
    input wire logic undervoltage_lockout_ok_i,
    input wire logic policy_i,
    input wire logic alarm_out_n_o,
    input wire logic alarm_oe_o,
    input wire logic device_on_o,
    input wire logic switch_on_o,
    input wire logic boost_run_o,
    input wire logic [lrf_pkg::ROWS-1:0] gen_on_o,
    input wire logic [lrf_pkg::ROWS-1:0] row_active_o,
    input wire logic protect_o
);
    import lrf_pkg::*;
    // ==========================================================
    // helper logic
    logic hot; // fault that pulls alarm under any policy
    logic opn; // some row open
    longint cnt; // cycles of short while dimming is high
    assign hot = ovp_i | otp_i;
    assign opn = |open_row_i;
    // count pin-level short time, cleared on drop or off-phase
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt <= 0;
        end else begin
            cnt <= (|short_row_i && dimming_input_i) ? cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // ==========================================================
    // sequences
    sequence s_off_alarm;
        !device_on_o && !alarm_out_n_o;
    endsequence
    sequence s_quiet;
        (!enable_i || !undervoltage_lockout_ok_i)[*4];
    endsequence
    // ==========================================================
    // assertions
    oe_polarity_a: assert property (alarm_oe_o == !alarm_out_n_o)
        else $error("alarm enable not inverse of alarm level");
    armed_run_a: assert property (protect_o |-> device_on_o)
        else $error("protection armed while device off");
    ocp_switch_a: assert property (ocp_i[*4] |-> !switch_on_o)
        else $error("switch on during overcurrent");
    ovp_latch_a: assert property (protect_o && ovp_i |-> ##[1:5] s_off_alarm)
        else $error("overvoltage did not shut down with alarm");
    thermal_off_a: assert property (protect_o && otp_i |-> ##[1:5] s_off_alarm)
        else $error("thermal fault did not shut down with alarm");
    dim_follow_a: assert property ((!dimming_input_i)[*4] ##0 protect_o
        |-> gen_on_o == '0 && !boost_run_o)
        else $error("generators or boost on in dimming off-phase");
    soft_duty_a: assert property (device_on_o && !protect_o |-> gen_on_o == row_active_o)
        else $error("soft-start duty not forced full");
    quiet_off_a: assert property (s_quiet |-> !device_on_o)
        else $error("device on while disabled or under lockout");
    fall_cause_a: assert property ($fell(alarm_out_n_o) |-> $past(hot, 3) || (!policy_i
        && ($past(opn, 3) || cnt >= MASK_CYC)))
        else $error("alarm fell without a qualifying fault");
endmodule
bind lrf_top lrf_top_chk #(.MASK_CYC(MASK_CYC)) i_chk (.*);

//--- test/lrf_alarm_host.sv
// host side of the open-collector alarm line with its pull-up
`timescale 1ns/1ps
module lrf_alarm_host (
    input wire logic alarm_oe_i,
    output wire logic alarm_wire_o
);
    // pull-up holds the line high unless the device sinks it
    assign alarm_wire_o = alarm_oe_i ? 1'b0 : 1'b1;
endmodule

//--- test/tb_top.sv
// self-checking testbench for the led row fault manager
`timescale 1ns/1ps
module tb_top;
    import lrf_pkg::*;
    logic mclk_i = 0, sys_rst_i = 1, ocp_i = 0, ovp_i = 0, otp_i = 0, enable_i = 0;
    logic dimming_input_i = 0, ss_done_i = 0, float_th_i = 0, undervoltage_lockout_ok_i = 1, policy_i = 0;
    logic [ROWS-1:0] open_row_i = 0, short_row_i = 0, gen_on_o, row_active_o;
    logic alarm_out_n_o, alarm_oe_o, device_on_o, switch_on_o, boost_run_o, protect_o;
    wire alarm_wire; // resolved alarm line
    int fails = 0, n_tests = 0;
    lrf_top #(.MASK_CYC(20)) i_dut (.*);
    lrf_alarm_host i_host (.alarm_oe_i(alarm_oe_o), .alarm_wire_o(alarm_wire));
    // 40 MHz clock
    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    // settle at falling edges before looking
    task automatic w(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic ck(input string nm, input logic [5:0] exp, input logic [5:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rst(input logic pol);
        @(posedge mclk_i);
        sys_rst_i <= 1;
        policy_i <= pol;
        w(20);
        ck("rst_alarm", 1, alarm_wire);
        ck("rst_rows", 6'h3f, row_active_o);
        @(posedge mclk_i);
        sys_rst_i <= 0;
    endtask
    task automatic t_start();
        @(posedge mclk_i);
        enable_i <= 1;
        dimming_input_i <= 0;
        w(8);
        ck("gen_soft", 6'h3f, gen_on_o);
        ck("armed_soft", 0, protect_o);
        @(posedge mclk_i);
        ss_done_i <= 1;
        dimming_input_i <= 1;
        w(8);
        ck("armed", 1, protect_o);
    endtask
    task automatic t_stop();
        @(posedge mclk_i);
        {enable_i, ss_done_i, ocp_i, ovp_i, otp_i, float_th_i} <= 0;
        {open_row_i, short_row_i} <= 0;
        w(8);
        ck("off", 0, device_on_o);
        ck("released", 1, alarm_wire);
    endtask
    // raise or drop one detector input, picked by number
    task automatic set_fault(input int sel, input logic v);
        case (sel)
            0: ocp_i <= v;
            1: ovp_i <= v;
            2: otp_i <= v;
            3: open_row_i[0] <= v;
            default: short_row_i[0] <= v;
        endcase
    endtask
    task automatic t_fault(input string nm, input int sel, input logic wire_exp,
                           input logic sw_exp);
        @(posedge mclk_i);
        set_fault(sel, 1);
        w(8);
        ck(nm, wire_exp, alarm_wire);
        ck("switch", sw_exp, switch_on_o);
        @(posedge mclk_i);
        set_fault(sel, 0);
        w(8);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // watchdog, run needs well under 2000 cycles
    initial begin
        #100000;
        fails++;
        give_verdict();
    end
    initial begin
        rst(0);
        t_start();
        t_fault("ocp_alarm", 0, 1, 0);
        ck("ocp_switch", 1, switch_on_o);
        @(posedge mclk_i);
        dimming_input_i <= 0;
        w(8);
        ck("gen_dim", 6'h00, gen_on_o);
        ck("boost_dim", 0, boost_run_o);
        t_fault("ovp_alarm", 1, 0, 0);
        ck("ovp_held", 0, alarm_wire);
        t_stop();
        t_start();
        t_fault("otp_alarm", 2, 0, 0);
        ck("otp_restart", 1, device_on_o);
        @(posedge mclk_i);
        short_row_i <= 6'h04;
        w(15);
        @(posedge mclk_i);
        dimming_input_i <= 0;
        @(posedge mclk_i);
        dimming_input_i <= 1;
        w(15);
        ck("short_masked", 1, alarm_wire);
        w(30);
        ck("short_alarm", 0, alarm_wire);
        t_stop();
        t_start();
        t_fault("open_strict", 3, 0, 0);
        @(posedge mclk_i);
        undervoltage_lockout_ok_i <= 0;
        w(8);
        @(posedge mclk_i);
        undervoltage_lockout_ok_i <= 1;
        w(8);
        ck("por_clear", 1, alarm_wire);
        t_stop();
        rst(1);
        t_start();
        @(posedge mclk_i);
        open_row_i <= 6'h02;
        w(8);
        ck("row_wait", 6'h3f, row_active_o);
        @(posedge mclk_i);
        float_th_i <= 1;
        w(8);
        ck("row_drop", 6'h3d, row_active_o);
        ck("gen_drop", 6'h3d, gen_on_o);
        ck("open_quiet", 1, alarm_wire);
        t_fault("short_off", 4, 1, 1);
        @(posedge mclk_i);
        short_row_i <= 6'h01;
        open_row_i <= 6'h00;
        w(50);
        ck("short_quiet", 1, alarm_wire);
        ck("short_run", 1, protect_o);
        ck("row_kept_out", 6'h3d, row_active_o);
        give_verdict();
    end
endmodule
